// File: common/aio_host_pkg.sv
/*
  constants, field layout and state carriers for the analog i/o backplane
  slave. assumes a 100 MHz core clock and a 16 MHz backplane clock pin.
*/
package aio_host_pkg;
  localparam int unsigned REF_CLK_HZ = 100_000_000; // core clock rate
  localparam int unsigned SYS_CLK_MHZ = 16; // backplane timer clock
  // analog timing intervals in ns
  localparam int unsigned SETTLE_NS = 8000;
  localparam int unsigned SETTLE_SHORT_NS = 6000;
  localparam int unsigned TRACK_NS = 2000;
  localparam int unsigned TRACK_SHORT_NS = 1500;
  // same intervals as backplane clock ticks, least times rounded up
  localparam logic [7:0] SETTLE_TICKS = 8'((SETTLE_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] SETTLE_SHORT_TICKS = 8'((SETTLE_SHORT_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] TRACK_TICKS = 8'((TRACK_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] TRACK_SHORT_TICKS = 8'((TRACK_SHORT_NS * SYS_CLK_MHZ + 999) / 1000);
  // address modifiers for short i/o space
  localparam logic [5:0] AM_SHORT_SUP = 6'h2d;
  localparam logic [5:0] AM_SHORT_NPRIV = 6'h29;
  // word indices inside the 64-byte window
  localparam logic [4:0] SHARED_IDX = 5'h00; // shared_control_status_location
  localparam logic [4:0] CDR_IDX = 5'h01; // converter data
  localparam int unsigned DAC_SEL_BIT = 4; // words 16..31 are output memory
  // control field positions
  localparam int unsigned CTL_MUX_LSB = 0;
  localparam int unsigned CTL_START_SETTLE = 4;
  localparam int unsigned CTL_EN_CONV = 5;
  localparam int unsigned CTL_SHORT = 6;
  localparam int unsigned CTL_INTERLEAVE = 7;
  localparam int unsigned CTL_CODE_LSB = 8;
  localparam int unsigned CTL_OFFLINE = 10;
  localparam int unsigned CTL_FAST_REF = 11;
  localparam int unsigned CTL_LOOPBACK = 12;
  localparam logic [12:0] CTL_RESET = 13'h0000;
  typedef enum logic [1:0] {
    CODE_STRAIGHT = 2'b00,
    CODE_OFFSET = 2'b01,
    CODE_TWOS = 2'b10
  } code_e;
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_e;
  // every pin sampled from outside the core clock domain
  typedef struct packed {
    logic as_n;
    logic [1:0] ds_n;
    logic write_n;
    logic [15:1] addr;
    logic [5:0] am;
    logic [15:0] data;
    logic [9:0] base_sel;
    logic am_sup_sel;
    logic sys_clk;
    logic sys_reset_n;
    logic adc_done;
    logic [11:0] adc_data;
  } pins_s;
  typedef struct packed {
    pins_s s1; // first synchroniser stage
    pins_s s2; // second synchroniser stage
    bus_e bus;
    logic ack;
    logic [15:0] rd_data;
    logic rd_oe;
    logic [12:0] ctl;
    logic ndr;
    logic conv_busy;
    logic settle_busy;
    logic tracking;
    logic settled;
    logic conv_pend;
    logic converting;
    logic adc_conv;
    logic [7:0] settle_cnt;
    logic sclk_prev;
    logic done_prev;
    logic [11:0] cdr;
    logic [15:0][11:0] mem;
    logic [11:0] ref_data;
  } state_s;
  localparam state_s STATE_RESET = '0;
endpackage

// File: src/aio_host_port.sv
/*
  backplane slave of the 16-channel analog i/o board: window decode, board
  select, acknowledge, control/status word, converter sequencer and the
  16-word output memory with its refresh read port.
  assumes all backplane pins are asynchronous and resolved to wire levels
  by the bench; refresh_addr_i comes from logic on ref_clk_i.
*/
`timescale 1ns/100ps
module aio_host_port
  import aio_host_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic vme_as_n_i,
  input wire logic [1:0] vme_ds_n_i,
  input wire logic vme_write_n_i,
  input wire logic [15:1] vme_addr_i,
  input wire logic [5:0] vme_am_i,
  input wire logic [15:0] vme_data_i,
  output logic [15:0] vme_data_o,
  output logic vme_data_oe_o,
  output logic vme_dtack_n_o,
  output logic vme_dtack_oe_o,
  input wire logic [9:0] base_sel_i,
  input wire logic am_sup_sel_i,
  input wire logic sys_clk_i,
  input wire logic sys_reset_n_i,
  input wire logic adc_done_i,
  input wire logic [11:0] adc_data_i,
  output logic adc_conv_o,
  output logic track_o,
  output logic [3:0] mux_addr_o,
  input wire logic [3:0] refresh_addr_i,
  output logic [11:0] refresh_data_o,
  output logic offline_o,
  output logic fast_refresh_o,
  output logic loopback_o
);
  state_s st_ff; // all registered state
  state_s nxt_st; // next value of all state
  pins_s pins_now; // raw pin bundle
  logic [5:0] am_want; // modifier chosen by jumper
  logic sel; // board selected this cycle
  logic ds_any; // at least one data strobe low
  logic [4:0] widx; // word index in window
  logic [15:0] status_w; // status view of shared location
  logic [15:0] cdr_coded; // sample in selected coding
  logic [15:0] rd_word; // read mux result
  logic tick; // one backplane clock rising edge

  assign pins_now = '{vme_as_n_i, vme_ds_n_i, vme_write_n_i, vme_addr_i, vme_am_i,
    vme_data_i, base_sel_i, am_sup_sel_i, sys_clk_i, sys_reset_n_i, adc_done_i,
    adc_data_i};

  // board select compares only second-stage samples
  assign am_want = st_ff.s2.am_sup_sel ? AM_SHORT_SUP : AM_SHORT_NPRIV;
  assign sel = !st_ff.s2.as_n && (st_ff.s2.addr[15:6] == st_ff.s2.base_sel)
    && (st_ff.s2.am == am_want);
  assign ds_any = (st_ff.s2.ds_n != 2'b11);
  assign widx = st_ff.s2.addr[5:1];
  assign tick = st_ff.s2.sys_clk && !st_ff.sclk_prev;
  // flags above mirrored control bits
  assign status_w = {st_ff.ndr, st_ff.conv_busy, st_ff.settle_busy, st_ff.ctl};

  // coding applied on read, so a coding change needs no reconversion
  always_comb begin
    case (code_e'(st_ff.ctl[CTL_CODE_LSB +: 2]))
      CODE_TWOS: cdr_coded = {{4{~st_ff.cdr[11]}}, ~st_ff.cdr[11], st_ff.cdr[10:0]};
      default: cdr_coded = {4'h0, st_ff.cdr}; // straight and offset share bits
    endcase
  end

  // read mux over the window
  always_comb begin
    if (widx[DAC_SEL_BIT]) begin
      rd_word = {4'h0, st_ff.mem[widx[3:0]]};
    end else if (widx == SHARED_IDX) begin
      rd_word = status_w;
    end else if (widx == CDR_IDX) begin
      rd_word = cdr_coded;
    end else begin
      rd_word = 16'h0000;
    end
  end

  // whole next-state computation
  always_comb begin
    logic [15:0] old_w;
    logic [15:0] wr_w;
    logic start_req;
    logic conv_req;
    old_w = 16'h0000;
    wr_w = 16'h0000;
    start_req = 1'b0;
    conv_req = 1'b0;
    nxt_st = st_ff;
    nxt_st.s1 = pins_now;
    nxt_st.s2 = st_ff.s1;
    nxt_st.sclk_prev = st_ff.s2.sys_clk;
    nxt_st.done_prev = st_ff.s2.adc_done;
    nxt_st.adc_conv = 1'b0;
    nxt_st.ref_data = st_ff.mem[refresh_addr_i];
    // backplane handshake
    case (st_ff.bus)
      BUS_IDLE: begin
        if (sel && ds_any) begin
          nxt_st.bus = BUS_ACK;
          nxt_st.ack = 1'b1;
          if (st_ff.s2.write_n) begin
            nxt_st.rd_data = rd_word;
            nxt_st.rd_oe = 1'b1;
            if (widx == CDR_IDX) begin
              nxt_st.ndr = 1'b0;
              nxt_st.conv_busy = 1'b0;
            end
          end else begin
            // merge written byte lanes over current contents
            if (widx[DAC_SEL_BIT]) begin
              old_w = {4'h0, st_ff.mem[widx[3:0]]};
            end else begin
              old_w = {3'b000, st_ff.ctl};
            end
            wr_w[15:8] = st_ff.s2.ds_n[1] ? old_w[15:8] : st_ff.s2.data[15:8];
            wr_w[7:0] = st_ff.s2.ds_n[0] ? old_w[7:0] : st_ff.s2.data[7:0];
            if (widx[DAC_SEL_BIT]) begin
              nxt_st.mem[widx[3:0]] = wr_w[11:0];
            end else if (widx == SHARED_IDX) begin
              nxt_st.ctl = wr_w[12:0];
              nxt_st.ctl[CTL_START_SETTLE] = 1'b0; // start bits act once
              nxt_st.ctl[CTL_EN_CONV] = 1'b0;
              start_req = wr_w[CTL_START_SETTLE];
              conv_req = wr_w[CTL_EN_CONV];
            end
            // other words ignore writes
          end
        end
      end
      BUS_ACK: begin
        if (!ds_any) begin
          nxt_st.bus = BUS_IDLE;
          nxt_st.ack = 1'b0;
          nxt_st.rd_oe = 1'b0;
        end
      end
      default: begin
        nxt_st.bus = BUS_IDLE;
      end
    endcase
    // settling then tracking, each counted in backplane ticks
    if (st_ff.settle_busy && tick) begin
      if (st_ff.settle_cnt <= 8'h01) begin
        if (!st_ff.tracking) begin
          nxt_st.tracking = 1'b1;
          nxt_st.settle_cnt = st_ff.ctl[CTL_SHORT] ? TRACK_SHORT_TICKS : TRACK_TICKS;
        end else begin
          nxt_st.tracking = 1'b0;
          nxt_st.settle_busy = 1'b0;
          nxt_st.settled = 1'b1;
        end
      end else begin
        nxt_st.settle_cnt = st_ff.settle_cnt - 8'h01;
      end
    end
    // new settling; blocked during a conversion unless interleaved
    if (start_req && (!st_ff.converting || nxt_st.ctl[CTL_INTERLEAVE])) begin
      nxt_st.settle_busy = 1'b1;
      nxt_st.tracking = 1'b0;
      nxt_st.settled = 1'b0;
      nxt_st.settle_cnt = nxt_st.ctl[CTL_SHORT] ? SETTLE_SHORT_TICKS : SETTLE_TICKS;
    end
    if (conv_req) begin
      nxt_st.conv_busy = 1'b1;
      nxt_st.conv_pend = 1'b1;
    end
    // conversion completes: the set wins over a same-cycle read clear
    if (st_ff.converting && st_ff.s2.adc_done && !st_ff.done_prev) begin
      nxt_st.converting = 1'b0;
      nxt_st.cdr = st_ff.s2.adc_data;
      nxt_st.ndr = 1'b1;
    end
    // hold and convert once settled, with the converter free
    if (nxt_st.settled && nxt_st.conv_pend && !nxt_st.converting) begin
      nxt_st.adc_conv = 1'b1;
      nxt_st.converting = 1'b1;
      nxt_st.conv_pend = 1'b0;
      nxt_st.settled = 1'b0;
    end
    // backplane reset clears timers and flags, keeps mode latches
    if (!st_ff.s2.sys_reset_n) begin
      nxt_st.ndr = 1'b0;
      nxt_st.conv_busy = 1'b0;
      nxt_st.settle_busy = 1'b0;
      nxt_st.tracking = 1'b0;
      nxt_st.settled = 1'b0;
      nxt_st.conv_pend = 1'b0;
      nxt_st.converting = 1'b0;
      nxt_st.adc_conv = 1'b0;
      nxt_st.settle_cnt = 8'h00;
    end
  end

  // single state register, frozen while ce_i is low
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_ff <= STATE_RESET;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from state flops
  assign vme_data_o = st_ff.rd_data;
  assign vme_data_oe_o = st_ff.rd_oe;
  assign vme_dtack_n_o = ~st_ff.ack;
  assign vme_dtack_oe_o = st_ff.ack; // open collector: drive only low
  assign adc_conv_o = st_ff.adc_conv;
  assign track_o = st_ff.tracking;
  assign mux_addr_o = st_ff.ctl[CTL_MUX_LSB +: 4];
  assign refresh_data_o = st_ff.ref_data;
  assign offline_o = st_ff.ctl[CTL_OFFLINE];
  assign fast_refresh_o = st_ff.ctl[CTL_FAST_REF];
  assign loopback_o = st_ff.ctl[CTL_LOOPBACK];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  AST_NO_ACK_UNSELECTED: assert property ($rose(st_ff.ack) |-> $past(sel))
    else $error("acknowledge without board select");
  AST_ACK_FOLLOWS_SELECT: assert property (
    (st_ff.bus == BUS_IDLE && sel && ds_any) |=> st_ff.ack && !vme_dtack_n_o)
    else $error("selected strobe not acknowledged next cycle");
  AST_ACK_RELEASED: assert property (
    (st_ff.ack && !ds_any) |=> !st_ff.ack && !vme_data_oe_o)
    else $error("acknowledge held after strobes released");
  AST_SHARED_READS_STATUS: assert property (
    (st_ff.bus == BUS_IDLE && sel && ds_any && st_ff.s2.write_n && widx == SHARED_IDX)
    |=> vme_data_o == $past(status_w))
    else $error("shared location read did not return status");
  AST_UNMAPPED_ZERO: assert property (
    (st_ff.bus == BUS_IDLE && sel && ds_any && st_ff.s2.write_n
     && !widx[DAC_SEL_BIT] && widx > CDR_IDX) |=> vme_data_o == 16'h0000)
    else $error("undefined word read nonzero");
  AST_DAC_WRITE_STORED: assert property (
    (st_ff.bus == BUS_IDLE && sel && !st_ff.s2.write_n && st_ff.s2.ds_n == 2'b00
     && widx[DAC_SEL_BIT]) |=> st_ff.mem[$past(widx[3:0])] == $past(st_ff.s2.data[11:0]))
    else $error("output word write lost");
  AST_TIMER_ONLY_ON_TICK: assert property (
    (st_ff.settle_busy && !tick && st_ff.s2.sys_reset_n && st_ff.bus == BUS_ACK)
    |=> st_ff.settle_cnt == $past(st_ff.settle_cnt))
    else $error("timer moved without backplane clock edge");
  AST_SYSRESET_CLEARS: assert property (
    !st_ff.s2.sys_reset_n |=> !st_ff.ndr && !st_ff.conv_busy && !st_ff.settle_busy)
    else $error("backplane reset left a flag set");
  AST_TWOS_CODING: assert property (
    (st_ff.ctl[CTL_CODE_LSB +: 2] == CODE_TWOS) |-> cdr_coded[11] == ~st_ff.cdr[11])
    else $error("two's complement coding wrong");
  AST_CONV_AFTER_SETTLE: assert property (
    $rose(st_ff.adc_conv) |-> !st_ff.settle_busy && !st_ff.tracking)
    else $error("conversion started during settling");

  COV_READ_CYCLE: cover property (st_ff.ack && st_ff.rd_oe ##[1:20] !st_ff.ack);
  COV_CONVERSION: cover property ($rose(st_ff.adc_conv) ##[1:1000] $rose(st_ff.ndr));
  COV_INTERLEAVED: cover property (st_ff.converting && st_ff.settle_busy);
  COV_DAC_WRITE: cover property (st_ff.ack && !st_ff.s2.write_n && widx[DAC_SEL_BIT]);

endmodule // aio_host_port

// File: verification/aio_bus_master.sv
/*
  behavioural backplane master running single word cycles on the slave pins.
  assumes one core clock and a pulled-up acknowledge wire.
*/
`timescale 1ns/100ps
module aio_bus_master
  import aio_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic dtack_oe_i,
  input wire logic [15:0] bus_data_i,
  output logic as_n_o,
  output logic [1:0] ds_n_o,
  output logic write_n_o,
  output logic [15:1] addr_o,
  output logic [5:0] am_o,
  output logic [15:0] data_o
);
  // idle pins at time zero
  initial begin
    as_n_o = 1'b1;
    ds_n_o = 2'b11;
    write_n_o = 1'b1;
    addr_o = '0;
    am_o = '0;
    data_o = '0;
  end
  // one word cycle; both lanes strobed, held until acknowledge is sampled or 12 cycles pass
  task automatic xfer(input logic wr, input logic [15:1] a, input logic [5:0] m,
      input logic [15:0] wd, output logic [15:0] rd, output logic acked, output logic freed);
    int n;
    acked = 1'b0;
    freed = 1'b0;
    rd = '0;
    @(posedge clk_i);
    as_n_o <= 1'b0;
    ds_n_o <= 2'b00;
    write_n_o <= ~wr;
    addr_o <= a;
    am_o <= m;
    data_o <= wd;
    for (n = 0; n < 12 && !acked; n++) begin
      @(posedge clk_i);
      // pre-edge value, so no race with the slave's own update
      if (dtack_oe_i === 1'b1) begin
        acked = 1'b1;
        rd = bus_data_i;
      end
    end
    // withdraw the command; released lines show the inverse, never stale data
    as_n_o <= 1'b1;
    ds_n_o <= 2'b11;
    addr_o <= ~a;
    am_o <= ~m;
    data_o <= ~wd;
    for (n = 0; n < 8 && !freed; n++) begin
      @(posedge clk_i);
      freed = (dtack_oe_i === 1'b0);
    end
    // let the slave's synchroniser see the strobes high
    repeat (3) @(posedge clk_i);
  endtask
endmodule // aio_bus_master

// File: verification/tb.sv
/*
  self-checking bench for the analog i/o backplane slave.
  assumes the bus master model and a free-running 16 MHz backplane clock.
*/
`timescale 1ns/100ps
module tb;
  import aio_host_pkg::*;
  logic clk = 1'b0;
  logic sys_clk = 1'b0;
  logic rst_n, sys_rst_n, adc_done, am_sup, data_oe, dtack_n, dtack_oe, as_n, write_n;
  logic conv, trk, offl, fast, loopb;
  logic [9:0] base, base_use;
  logic [5:0] am, am_use;
  logic [3:0] raddr, mux;
  logic [1:0] ds_n;
  logic [15:1] addr;
  logic [11:0] rdata;
  logic [15:0] host_data, data_o, wire_data, rd;
  int fail_count, num_checks;
  // slave drives the wire only while its enable is high
  assign wire_data = (data_oe === 1'b1) ? data_o : host_data;
  always #5 clk = ~clk;
  always #31.25 sys_clk = ~sys_clk;
  aio_bus_master host (.clk_i(clk), .dtack_oe_i(dtack_oe), .bus_data_i(wire_data),
    .as_n_o(as_n), .ds_n_o(ds_n), .write_n_o(write_n), .addr_o(addr), .am_o(am),
    .data_o(host_data));
  aio_host_port uut (.ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .vme_as_n_i(as_n),
    .vme_ds_n_i(ds_n), .vme_write_n_i(write_n), .vme_addr_i(addr), .vme_am_i(am),
    .vme_data_i(wire_data), .vme_data_o(data_o), .vme_data_oe_o(data_oe),
    .vme_dtack_n_o(dtack_n), .vme_dtack_oe_o(dtack_oe), .base_sel_i(base),
    .am_sup_sel_i(am_sup), .sys_clk_i(sys_clk), .sys_reset_n_i(sys_rst_n),
    .adc_done_i(adc_done), .adc_data_i(12'h9c3), .adc_conv_o(conv), .track_o(trk),
    .mux_addr_o(mux), .refresh_addr_i(raddr), .refresh_data_o(rdata),
    .offline_o(offl), .fast_refresh_o(fast), .loopback_o(loopb));
  // converter stand-in: done edge some time after each start pulse
  always begin
    @(posedge clk);
    if (conv === 1'b1) begin
      repeat (40) @(posedge clk);
      adc_done <= 1'b1;
      repeat (4) @(posedge clk);
      adc_done <= 1'b0;
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // word access at the current base and modifier; a missing answer ends the run
  task automatic acc(input logic wr, input logic [4:0] w, input logic [15:0] wd,
      input logic ok);
    logic ak, fr;
    host.xfer(wr, {base_use, w}, am_use, wd, rd, ak, fr);
    chk("ack", {15'h0, ok}, {15'h0, ak});
    chk("release", 16'h1, {15'h0, fr});
    if ((ok && !ak) || !fr) complete_run();
  endtask
  task automatic t_reset();
    chk("idle wire", 16'h4, {13'h0, dtack_n, dtack_oe, data_oe});
    chk("idle outs", 16'h0, {9'h0, conv, trk, mux, offl});
  endtask
  task automatic t_csr();
    acc(1'b1, SHARED_IDX, 16'h1e05, 1'b1);
    chk("mode pins", 16'h0075, {9'h0, offl, fast, loopb, mux});
    acc(1'b0, SHARED_IDX, 16'h0, 1'b1);
    chk("status", 16'h1e05, rd);
  endtask
  task automatic t_mem();
    for (int k = 0; k < 16; k++) acc(1'b1, 5'(16 + k), {4'ha, 4'(k), ~4'(k), 4'(k)}, 1'b1);
    for (int k = 0; k < 16; k++) begin
      acc(1'b0, 5'(16 + k), 16'h0, 1'b1);
      chk("out word", {4'h0, 4'(k), ~4'(k), 4'(k)}, rd);
      @(posedge clk);
      raddr <= 4'(15 - k);
      repeat (2) @(posedge clk);
      chk("refresh", {4'h0, 4'(15 - k), ~4'(15 - k), 4'(15 - k)}, {4'h0, rdata});
    end
  endtask
  task automatic t_select();
    base_use = base ^ 10'h200;
    acc(1'b1, SHARED_IDX, 16'h0, 1'b0);
    base_use = base;
    am_use = AM_SHORT_NPRIV;
    acc(1'b1, SHARED_IDX, 16'h0, 1'b0);
    @(posedge clk);
    am_sup <= 1'b0;
    repeat (4) @(posedge clk);
    acc(1'b0, SHARED_IDX, 16'h0, 1'b1);
    chk("kept", 16'h1e05, rd);
    @(posedge clk);
    am_sup <= 1'b1;
    am_use = AM_SHORT_SUP;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_hole();
    acc(1'b1, 5'h0f, 16'hffff, 1'b1);
    acc(1'b0, 5'h0f, 16'h0, 1'b1);
    chk("hole", 16'h0, rd);
  endtask
  task automatic t_sysrst();
    acc(1'b1, SHARED_IDX, 16'h1e15, 1'b1);
    repeat (20) @(posedge clk);
    acc(1'b0, SHARED_IDX, 16'h0, 1'b1);
    chk("settling", 16'h3e05, rd);
    sys_rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    sys_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    acc(1'b0, SHARED_IDX, 16'h0, 1'b1);
    chk("after sysreset", 16'h1e05, rd);
  endtask
  task automatic t_conv();
    int cyc, tcyc;
    cyc = 0;
    tcyc = 0;
    acc(1'b1, SHARED_IDX, 16'h0230, 1'b1);
    while (conv !== 1'b1) begin
      @(posedge clk);
      cyc++;
      if (trk === 1'b1) tcyc++;
      if (cyc > 2000) begin
        fail_count++;
        complete_run();
      end
    end
    // 160 ticks of 6.25 cycles from the write, less the handshake tail of acc
    chk("delay", 16'h1, {15'h0, cyc >= 984 && cyc <= 1000});
    chk("tracking", 16'h1, {15'h0, tcyc >= 194 && tcyc <= 206});
    repeat (80) @(posedge clk);
    acc(1'b0, SHARED_IDX, 16'h0, 1'b1);
    chk("done flags", 16'hc200, rd);
    acc(1'b0, CDR_IDX, 16'h0, 1'b1);
    chk("twos sample", 16'h01c3, rd);
    acc(1'b0, SHARED_IDX, 16'h0, 1'b1);
    chk("flags cleared", 16'h0200, rd);
  endtask
  initial begin
    fail_count = 0;
    num_checks = 0;
    rst_n = 1'b0;
    sys_rst_n = 1'b1;
    adc_done = 1'b0;
    am_sup = 1'b1;
    base = 10'h221;
    base_use = 10'h221;
    am_use = AM_SHORT_SUP;
    raddr = 4'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_csr();
    t_mem();
    t_select();
    t_hole();
    t_sysrst();
    t_conv();
    complete_run();
  end
endmodule // tb
